//--- design/anl_pkg.sv
/*
 * constants, types and helpers of the block-transfer link engine.
 * assumes a byte layer below that serialises o_tx bytes and returns received bytes.
 */
// Functional notes
// - EOT releases link and aborts phase two
// - ENQ requests link and prompts block response
// - ACK is the positive response
// - NAK is the negative response
// - header and terminator codes always mark blocks
// - default SOH, STX headers, ETX terminator
// - header and terminator bytes are programmable
// - heading block then data blocks, optional fields
// - five digit serial 00001 to 32767
// - send ENQ, enter phase two on ACK
// - resend ENQ every three seconds until limit
// - phase one retry count configurable, default ten
// - after last ENQ wait, send EOT, abnormal
// - idle timeout configurable, default thirty seconds
// - heading, then next block per ACK, then release
// - on NAK resend the same block at once
// - ten NAKs or send failure end abnormally
// - EOT in phase two ends abnormally
// - no response: ENQ every three seconds, nine times
// - after ninth ENQ wait, send EOT, abnormal
// - phase three EOT, ACK completes normally
// - resend EOT every three seconds, ten times
// - no ACK after tenth EOT ends abnormally
// - BCC after terminator, even column parity
package anl_pkg;
	// ==========================================================
	// control codes
	localparam logic [7:0] C_EOT = 8'h04;
	localparam logic [7:0] C_ENQ = 8'h05;
	localparam logic [7:0] C_ACK = 8'h06;
	localparam logic [7:0] C_NAK = 8'h15;
	localparam logic [7:0] C_SOH = 8'h01;
	localparam logic [7:0] C_STX = 8'h02;
	localparam logic [7:0] C_ETX = 8'h03;
	localparam logic [7:0] C_DIG0 = 8'h30;
	// ==========================================================
	// register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CFG  = 8'h04;
	localparam logic [7:0] A_CHAR = 8'h08;
	localparam logic [7:0] A_TICK = 8'h0c;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_SN   = 8'h14;
	localparam int B_START  = 0;
	localparam int B_ABORT  = 1;
	localparam int B_SN_EN  = 2;
	localparam int B_BCC_EN = 3;
	// ==========================================================
	// counts and times
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned SEC_TIME_S   = 1;
	localparam int unsigned CYC_PER_S    = CLK_HZ * SEC_TIME_S;
	localparam int unsigned RETRY_TIME_S = 3;
	localparam logic [7:0]  RETRY_SECS   = 8'(RETRY_TIME_S);
	localparam logic [7:0]  IDLE_DFLT_S  = 8'h1e;
	localparam logic [7:0]  ENQ_LIM_DFLT = 8'h0a;
	localparam logic [7:0]  P2_ENQ_MAX   = 8'h09;
	localparam logic [7:0]  NAK_MAX      = 8'h0a;
	localparam logic [7:0]  P3_EOT_MAX   = 8'h0a;
	localparam logic [19:0] SN_FIRST     = 20'h00001;
	localparam logic [19:0] SN_LAST      = 20'h32767;
	// ==========================================================
	// types
	typedef enum logic [1:0] {ST_IDLE, ST_CTL, ST_BLK, ST_WAIT} anl_state_t;
	typedef enum logic [1:0] {PH_1, PH_2, PH_3} anl_phase_t;
	typedef enum logic [2:0] {SP_HDR, SP_SN, SP_BODY, SP_TRM, SP_BCC} anl_step_t;
	// five-digit decimal increment, wrapping to the first value
	function automatic logic [19:0] sn_inc(input logic [19:0] v);
		logic [19:0] r;
		logic        cy;
		r  = v;
		cy = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (cy) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					cy = 1'b0;
				end
			end
		end
		if (v == SN_LAST) begin
			r = SN_FIRST;
		end
		return r;
	endfunction : sn_inc
endpackage : anl_pkg

//--- design/anl_sec_timer.sv
/*
 * whole-second timer: one pulse after i_secs seconds counted from the last restart.
 * assumes i_cyc_per_s is at least one and stays stable while armed.
 */
`timescale 1ns/1ps
module anl_sec_timer #(
	parameter int unsigned P_W = 32
) (
	input  wire logic           i_ref_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_restart,
	input  wire logic [P_W-1:0] i_cyc_per_s,
	input  wire logic [7:0]     i_secs,
	output logic                o_expire
);
	if (P_W < 2 || P_W > 32) begin : g_chk
		$error("anl_sec_timer: P_W out of range");
	end
	logic [P_W-1:0] cyc_ff, nxt_cyc;
	logic [7:0]     sec_ff, nxt_sec;
	logic           armed_ff, nxt_armed;
	logic           exp_ff, nxt_exp;
	// ==========================================================
	// counting
	always_comb begin
		nxt_cyc   = cyc_ff + 1'b1;
		nxt_sec   = sec_ff;
		nxt_armed = armed_ff;
		nxt_exp   = 1'b0;
		if (i_restart) begin
			nxt_cyc   = '0;
			nxt_sec   = '0;
			nxt_armed = 1'b1;
		end else if (armed_ff) begin
			if (nxt_cyc >= i_cyc_per_s) begin
				nxt_cyc = '0;
				nxt_sec = sec_ff + 1'b1;
				if (nxt_sec >= i_secs) begin
					nxt_exp   = 1'b1;
					nxt_armed = 1'b0;
				end
			end
		end else begin
			nxt_cyc = '0;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc_ff   <= '0;
			sec_ff   <= '0;
			armed_ff <= 1'b0;
			exp_ff   <= 1'b0;
		end else begin
			cyc_ff   <= nxt_cyc;
			sec_ff   <= nxt_sec;
			armed_ff <= nxt_armed;
			exp_ff   <= nxt_exp;
		end
	end
	assign o_expire = exp_ff;
endmodule : anl_sec_timer

//--- design/anl_bcc.sv
/*
 * block check accumulator: column-wise even parity of the bytes presented.
 * assumes i_clr and i_en are never high together.
 */
`timescale 1ns/1ps
module anl_bcc (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_clr,
	input  wire logic       i_en,
	input  wire logic [7:0] i_byte,
	output logic      [7:0] o_bcc
);
	logic [7:0] acc_ff, nxt_acc;
	always_comb begin
		nxt_acc = acc_ff;
		if (i_clr) begin
			nxt_acc = '0;
		end else if (i_en) begin
			nxt_acc = acc_ff ^ i_byte;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
		end
	end
	assign o_bcc = acc_ff;
endmodule : anl_bcc

//--- design/anl_link.sv
/*
 * sending-station engine of the three-phase block-transfer link.
 * assumes a byte layer taking o_tx_data on o_tx_valid && i_tx_ready, a received-byte
 * strobe i_rx_valid, and a block source whose byte is already valid in the cycle that o_blk_rd is high.
 */
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module anl_link #(
	parameter int unsigned P_CYC_PER_SEC = anl_pkg::CYC_PER_S
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wr_data,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rd_data,
	output logic      [7:0]  o_tx_data,
	output logic             o_tx_valid,
	input  wire logic        i_tx_ready,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_valid,
	output logic             o_blk_rd,
	input  wire logic [7:0]  i_blk_data,
	input  wire logic        i_blk_last,
	input  wire logic        i_blk_final,
	output logic             o_blk_next,
	output logic             o_blk_rewind,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_abnormal
);
	if (P_CYC_PER_SEC < 1) begin : g_chk
		$error("anl_link: P_CYC_PER_SEC must be at least one");
	end
	anl_pkg::anl_state_t state_ff, nxt_state;
	anl_pkg::anl_phase_t phase_ff, nxt_phase;
	anl_pkg::anl_step_t  step_ff, nxt_step;
	logic [7:0]  retry_ff, nxt_retry, nak_ff, nxt_nak;
	logic        abn_ff, nxt_abn, done_ff, nxt_done, busy_ff, nxt_busy;
	logic        first_ff, nxt_first, final_ff, nxt_final, fin_ff, nxt_fin;
	logic [7:0]  tx_data_ff, nxt_tx_data;
	logic        tx_valid_ff, nxt_tx_valid, pend_ff, nxt_pend;
	logic        blk_rd_ff, nxt_blk_rd, next_ff, nxt_next, rewind_ff, nxt_rewind;
	logic [19:0] sn_ff, nxt_sn;
	logic [2:0]  sn_idx_ff, nxt_sn_idx;
	logic        sn_en_ff, bcc_en_ff;
	logic [7:0]  enq_lim_ff, idle_ff, soh_ff, stx_ff, etx_ff;
	logic [31:0] tick_ff, rd_data_ff;
	logic        take, tmr_restart, tmr_exp, blk_go, ctl_go, ctl_fin, bcc_en;
	logic [7:0]  ctl_byte, bcc_q, tmr_secs;
	logic        wr_ctrl, start_req, abort_req;
	logic        rx_ack, rx_nak, rx_eot;
	// ==========================================================
	// register writes
	assign wr_ctrl   = i_wr && (i_addr == anl_pkg::A_CTRL);
	assign start_req = wr_ctrl && i_wr_data[anl_pkg::B_START];
	assign abort_req = wr_ctrl && i_wr_data[anl_pkg::B_ABORT];
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sn_en_ff   <= 1'b0;
			bcc_en_ff  <= 1'b0;
			enq_lim_ff <= anl_pkg::ENQ_LIM_DFLT;
			idle_ff    <= anl_pkg::IDLE_DFLT_S;
			soh_ff     <= anl_pkg::C_SOH;
			stx_ff     <= anl_pkg::C_STX;
			etx_ff     <= anl_pkg::C_ETX;
			tick_ff    <= P_CYC_PER_SEC;
		end else if (i_wr) begin
			case (i_addr)
				anl_pkg::A_CTRL: begin
					sn_en_ff  <= i_wr_data[anl_pkg::B_SN_EN];
					bcc_en_ff <= i_wr_data[anl_pkg::B_BCC_EN];
				end
				anl_pkg::A_CFG: begin
					enq_lim_ff <= i_wr_data[7:0];
					idle_ff    <= i_wr_data[15:8];
				end
				anl_pkg::A_CHAR: begin
					soh_ff <= i_wr_data[7:0];
					stx_ff <= i_wr_data[15:8];
					etx_ff <= i_wr_data[23:16];
				end
				anl_pkg::A_TICK: tick_ff <= i_wr_data;
				default: ;
			endcase
		end
	end
	// ==========================================================
	// register reads, data one cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_data_ff <= '0;
		end else if (i_rd) begin
			case (i_addr)
				anl_pkg::A_CTRL: rd_data_ff <= {28'h0000000, bcc_en_ff, sn_en_ff, 2'h0};
				anl_pkg::A_CFG:  rd_data_ff <= {16'h0000, idle_ff, enq_lim_ff};
				anl_pkg::A_CHAR: rd_data_ff <= {8'h00, etx_ff, stx_ff, soh_ff};
				anl_pkg::A_TICK: rd_data_ff <= tick_ff;
				anl_pkg::A_STAT: rd_data_ff <= {8'h00, nak_ff, retry_ff, 2'h0, phase_ff, 1'b0,
				                                abn_ff, done_ff, busy_ff};
				anl_pkg::A_SN:   rd_data_ff <= {12'h000, sn_ff};
				default:         rd_data_ff <= '0;
			endcase
		end else begin
			rd_data_ff <= '0;
		end
	end
	// ==========================================================
	// timing and block check
	assign tmr_secs = (state_ff == anl_pkg::ST_WAIT) ? anl_pkg::RETRY_SECS : idle_ff;
	anl_sec_timer #(
		.P_W (32)
	) u_tmr (
		.i_ref_clk   (i_ref_clk),
		.i_rstn      (i_rstn),
		.i_restart   (tmr_restart),
		.i_cyc_per_s (tick_ff),
		.i_secs      (tmr_secs),
		.o_expire    (tmr_exp)
	);
	assign bcc_en = take && (state_ff == anl_pkg::ST_BLK) && (step_ff != anl_pkg::SP_HDR)
	                && (step_ff != anl_pkg::SP_BCC);
	anl_bcc u_bcc (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_clr     (blk_go),
		.i_en      (bcc_en),
		.i_byte    (tx_data_ff),
		.o_bcc     (bcc_q)
	);
	// ==========================================================
	// sequencer
	assign take   = tx_valid_ff && i_tx_ready;
	assign rx_ack = i_rx_valid && (i_rx_data == anl_pkg::C_ACK);
	assign rx_nak = i_rx_valid && (i_rx_data == anl_pkg::C_NAK);
	assign rx_eot = i_rx_valid && (i_rx_data == anl_pkg::C_EOT);
	always_comb begin
		nxt_state    = state_ff;
		nxt_phase    = phase_ff;
		nxt_step     = step_ff;
		nxt_retry    = retry_ff;
		nxt_nak      = nak_ff;
		nxt_abn      = abn_ff;
		nxt_done     = done_ff;
		nxt_first    = first_ff;
		nxt_final    = final_ff;
		nxt_fin      = fin_ff;
		nxt_tx_data  = tx_data_ff;
		nxt_tx_valid = tx_valid_ff;
		nxt_pend     = 1'b0;
		nxt_blk_rd   = 1'b0;
		nxt_next     = 1'b0;
		nxt_rewind   = 1'b0;
		nxt_sn       = sn_ff;
		nxt_sn_idx   = sn_idx_ff;
		tmr_restart  = 1'b0;
		blk_go       = 1'b0;
		ctl_go       = 1'b0;
		ctl_fin      = 1'b0;
		ctl_byte     = anl_pkg::C_EOT;
		if (take) begin
			nxt_tx_valid = 1'b0;
			tmr_restart  = 1'b1;
		end
		case (state_ff)
			anl_pkg::ST_IDLE: begin
				if (start_req) begin
					nxt_phase = anl_pkg::PH_1;
					nxt_retry = 8'h01;
					nxt_nak   = '0;
					nxt_abn   = 1'b0;
					nxt_done  = 1'b0;
					nxt_first = 1'b1;
					nxt_sn    = anl_pkg::SN_FIRST;
					ctl_go    = 1'b1;
					ctl_byte  = anl_pkg::C_ENQ;
				end
			end
			anl_pkg::ST_CTL: begin
				if (take) begin
					nxt_state = fin_ff ? anl_pkg::ST_IDLE : anl_pkg::ST_WAIT;
					nxt_done  = fin_ff;
				end
			end
			anl_pkg::ST_BLK: begin
				case (step_ff)
					anl_pkg::SP_HDR: begin
						if (take && sn_en_ff && !first_ff) begin
							nxt_step     = anl_pkg::SP_SN;
							nxt_sn_idx   = 3'd4;
							nxt_tx_data  = anl_pkg::C_DIG0 | {4'h0, sn_ff[19:16]};
							nxt_tx_valid = 1'b1;
						end else if (take) begin
							nxt_step = anl_pkg::SP_BODY;
						end
					end
					anl_pkg::SP_SN: begin
						if (take && sn_idx_ff == 3'd0) begin
							nxt_step = anl_pkg::SP_BODY;
						end else if (take) begin
							nxt_sn_idx   = sn_idx_ff - 3'd1;
							nxt_tx_data  = anl_pkg::C_DIG0 | {4'h0, sn_ff[nxt_sn_idx*4 +: 4]};
							nxt_tx_valid = 1'b1;
						end
					end
					anl_pkg::SP_BODY: begin
						if (pend_ff) begin
							nxt_tx_data  = i_blk_data;
							nxt_tx_valid = 1'b1;
							nxt_final    = i_blk_final;
							nxt_fin      = i_blk_last;
						end else if (take && fin_ff) begin
							nxt_step     = anl_pkg::SP_TRM;
							nxt_tx_data  = etx_ff;
							nxt_tx_valid = 1'b1;
						end else if (!tx_valid_ff) begin
							nxt_blk_rd = 1'b1;
							nxt_pend   = 1'b1;
						end
					end
					anl_pkg::SP_TRM: begin
						if (take && bcc_en_ff) begin
							nxt_step     = anl_pkg::SP_BCC;
							nxt_tx_data  = bcc_q ^ tx_data_ff;
							nxt_tx_valid = 1'b1;
						end else if (take) begin
							nxt_state = anl_pkg::ST_WAIT;
							nxt_retry = '0;
						end
					end
					default: begin
						if (take) begin
							nxt_state = anl_pkg::ST_WAIT;
							nxt_retry = '0;
						end
					end
				endcase
				if (tmr_exp) begin
					nxt_abn      = 1'b1;
					nxt_tx_valid = 1'b0;
					nxt_phase    = anl_pkg::PH_3;
					nxt_retry    = 8'h01;
					ctl_go       = 1'b1;
				end
			end
			anl_pkg::ST_WAIT: begin
				if (phase_ff == anl_pkg::PH_1 && rx_ack) begin
					nxt_phase = anl_pkg::PH_2;
					nxt_retry = '0;
					blk_go    = 1'b1;
				end else if (phase_ff == anl_pkg::PH_2 && rx_ack) begin
					nxt_nak = '0;
					if (final_ff) begin
						nxt_phase = anl_pkg::PH_3;
						nxt_retry = 8'h01;
						ctl_go    = 1'b1;
					end else begin
						nxt_next  = 1'b1;
						nxt_first = 1'b0;
						nxt_sn    = first_ff ? sn_ff : anl_pkg::sn_inc(sn_ff);
						blk_go    = 1'b1;
					end
				end else if (phase_ff == anl_pkg::PH_2 && rx_nak) begin
					if (nak_ff + 8'h01 >= anl_pkg::NAK_MAX) begin
						nxt_abn   = 1'b1;
						nxt_phase = anl_pkg::PH_3;
						nxt_retry = 8'h01;
						ctl_go    = 1'b1;
					end else begin
						nxt_nak    = nak_ff + 8'h01;
						nxt_rewind = 1'b1;
						blk_go     = 1'b1;
					end
				end else if (phase_ff == anl_pkg::PH_2 && rx_eot) begin
					nxt_abn   = 1'b1;
					nxt_phase = anl_pkg::PH_3;
					nxt_retry = 8'h01;
					ctl_go    = 1'b1;
				end else if (phase_ff == anl_pkg::PH_3 && rx_ack) begin
					nxt_state = anl_pkg::ST_IDLE;
					nxt_done  = 1'b1;
				end else if (tmr_exp) begin
					case (phase_ff)
						anl_pkg::PH_1: begin
							ctl_go = 1'b1;
							if (retry_ff < enq_lim_ff) begin
								nxt_retry = retry_ff + 8'h01;
								ctl_byte  = anl_pkg::C_ENQ;
							end else begin
								nxt_abn = 1'b1;
								ctl_fin = 1'b1;
							end
						end
						anl_pkg::PH_2: begin
							ctl_go = 1'b1;
							if (retry_ff < anl_pkg::P2_ENQ_MAX) begin
								nxt_retry = retry_ff + 8'h01;
								ctl_byte  = anl_pkg::C_ENQ;
							end else begin
								nxt_abn = 1'b1;
								ctl_fin = 1'b1;
							end
						end
						default: begin
							if (retry_ff < anl_pkg::P3_EOT_MAX) begin
								nxt_retry = retry_ff + 8'h01;
								ctl_go    = 1'b1;
							end else begin
								nxt_abn   = 1'b1;
								nxt_done  = 1'b1;
								nxt_state = anl_pkg::ST_IDLE;
							end
						end
					endcase
				end
			end
			default: nxt_state = anl_pkg::ST_IDLE;
		endcase
		if (abort_req && state_ff != anl_pkg::ST_IDLE) begin
			nxt_abn = 1'b1;
			ctl_go  = 1'b1;
			ctl_fin = 1'b1;
			blk_go  = 1'b0;
		end
		if (ctl_go) begin
			nxt_state    = anl_pkg::ST_CTL;
			nxt_tx_data  = ctl_byte;
			nxt_tx_valid = 1'b1;
			nxt_fin      = ctl_fin;
			tmr_restart  = 1'b1;
		end else if (blk_go) begin
			nxt_state    = anl_pkg::ST_BLK;
			nxt_step     = anl_pkg::SP_HDR;
			nxt_tx_data  = nxt_first ? soh_ff : stx_ff;
			nxt_tx_valid = 1'b1;
			nxt_fin      = 1'b0;
			tmr_restart  = 1'b1;
		end
		nxt_busy = (nxt_state != anl_pkg::ST_IDLE);
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff    <= anl_pkg::ST_IDLE;
			phase_ff    <= anl_pkg::PH_1;
			step_ff     <= anl_pkg::SP_HDR;
			retry_ff    <= '0;
			nak_ff      <= '0;
			abn_ff      <= 1'b0;
			done_ff     <= 1'b0;
			busy_ff     <= 1'b0;
			first_ff    <= 1'b1;
			final_ff    <= 1'b0;
			fin_ff      <= 1'b0;
			tx_data_ff  <= '0;
			tx_valid_ff <= 1'b0;
			pend_ff     <= 1'b0;
			blk_rd_ff   <= 1'b0;
			next_ff     <= 1'b0;
			rewind_ff   <= 1'b0;
			sn_ff       <= anl_pkg::SN_FIRST;
			sn_idx_ff   <= '0;
		end else begin
			state_ff    <= nxt_state;
			phase_ff    <= nxt_phase;
			step_ff     <= nxt_step;
			retry_ff    <= nxt_retry;
			nak_ff      <= nxt_nak;
			abn_ff      <= nxt_abn;
			done_ff     <= nxt_done;
			busy_ff     <= nxt_busy;
			first_ff    <= nxt_first;
			final_ff    <= nxt_final;
			fin_ff      <= nxt_fin;
			tx_data_ff  <= nxt_tx_data;
			tx_valid_ff <= nxt_tx_valid;
			pend_ff     <= nxt_pend;
			blk_rd_ff   <= nxt_blk_rd;
			next_ff     <= nxt_next;
			rewind_ff   <= nxt_rewind;
			sn_ff       <= nxt_sn;
			sn_idx_ff   <= nxt_sn_idx;
		end
	end
	assign o_rd_data    = rd_data_ff;
	assign o_tx_data    = tx_data_ff;
	assign o_tx_valid   = tx_valid_ff;
	assign o_blk_rd     = blk_rd_ff;
	assign o_blk_next   = next_ff;
	assign o_blk_rewind = rewind_ff;
	assign o_busy       = busy_ff;
	assign o_done       = done_ff;
	assign o_abnormal   = abn_ff;
	// ==========================================================
	// checks
	a_p1_ack_enter: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_WAIT && phase_ff == anl_pkg::PH_1 && rx_ack && !abort_req
		|=> phase_ff == anl_pkg::PH_2 && o_tx_valid && step_ff == anl_pkg::SP_HDR)
		else $error("phase one ack did not start the heading block");
	a_hdr_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_BLK && step_ff == anl_pkg::SP_HDR && o_tx_valid
		|-> o_tx_data == (first_ff ? soh_ff : stx_ff))
		else $error("block header byte wrong");
	a_bcc_even: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_BLK && step_ff == anl_pkg::SP_BCC && o_tx_valid
		|-> o_tx_data == bcc_q)
		else $error("block check byte wrong");
	a_nak_resend: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_WAIT && phase_ff == anl_pkg::PH_2 && rx_nak
		&& nak_ff < 8'h09 && !abort_req
		|=> o_blk_rewind && o_tx_valid && o_tx_data == (first_ff ? soh_ff : stx_ff))
		else $error("nak did not resend the block");
	a_eot_abort: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_WAIT && phase_ff == anl_pkg::PH_2 && rx_eot
		|=> o_abnormal && o_tx_valid && o_tx_data == anl_pkg::C_EOT)
		else $error("eot in phase two not handled");
	a_p3_done: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_WAIT && phase_ff == anl_pkg::PH_3 && rx_ack && !abort_req
		|=> o_done && !o_busy && o_abnormal == $past(abn_ff))
		else $error("phase three ack did not complete");
	a_p2_enq_cap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		phase_ff == anl_pkg::PH_2 |-> retry_ff <= anl_pkg::P2_ENQ_MAX)
		else $error("phase two enquiry count exceeded");
	a_p1_giveup: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_ff == anl_pkg::ST_WAIT && phase_ff == anl_pkg::PH_1 && tmr_exp
		&& retry_ff >= enq_lim_ff && !i_rx_valid && !abort_req
		|=> o_tx_data == anl_pkg::C_EOT ##1 o_abnormal [*1])
		else $error("phase one give-up did not send eot");
endmodule : anl_link

//--- verification/anl_peer.sv
/*
 * receiving-station model: takes bytes at a slow ready and answers control bytes and blocks.
 * assumes answer inputs of 00 mean stay silent; the byte after the terminator is the bcc.
 */
`timescale 1ns/1ps
module anl_peer (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_ready,
	output logic      [7:0] o_rx_data,
	output logic            o_rx_valid,
	input  wire logic [7:0] i_r_enq,
	input  wire logic [7:0] i_r_blk,
	input  wire logic [7:0] i_r_eot,
	input  wire logic [7:0] i_term,
	input  wire logic       i_bcc_en
);
	logic [7:0] ans;
	logic [7:0] val_ff;
	logic [2:0] dly_ff;
	logic [1:0] rc_ff;
	logic       post_ff;
	// ==========================================================
	// answer choice and delayed reply
	assign o_tx_ready = rc_ff[1];
	assign ans = (post_ff || (i_tx_data == i_term && !i_bcc_en)) ? i_r_blk :
		(i_tx_data == anl_pkg::C_ENQ) ? i_r_enq : (i_tx_data == anl_pkg::C_EOT) ? i_r_eot : 8'h00;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rc_ff      <= 2'h0;
			dly_ff     <= 3'h0;
			val_ff     <= 8'h00;
			post_ff    <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
		end else begin
			rc_ff      <= rc_ff + 2'h1;
			o_rx_valid <= (dly_ff == 3'h1);
			// released line shows a changing pattern
			o_rx_data  <= (dly_ff == 3'h1) ? val_ff : ~o_rx_data;
			if (dly_ff != 3'h0) begin
				dly_ff <= dly_ff - 3'h1;
			end
			if (i_tx_valid && o_tx_ready) begin
				post_ff <= (i_tx_data == i_term) && i_bcc_en;
				if (ans != 8'h00) begin
					val_ff <= ans;
					dly_ff <= 3'h5;
				end
			end
		end
	end
endmodule : anl_peer

//--- verification/testbench.sv
/*
 * self-checking bench of the link engine: registers, a clean transfer and the abort paths.
 * assumes the peer model answers as set here; one second lasts TPS clock cycles.
 */
`timescale 1ns/1ps
module testbench;
	localparam int unsigned TPS = 20;
	logic        i_ref_clk, i_rstn, i_wr, i_rd, o_tx_valid, tx_ready, rx_valid, o_blk_rd, bcc_en;
	logic        i_blk_last, i_blk_final, o_blk_next, o_blk_rewind, o_busy, o_done, o_abnormal;
	logic [7:0]  i_addr, o_tx_data, rx_data, i_blk_data, r_enq, r_blk, r_eot, term;
	logic [31:0] i_wr_data, o_rd_data, d;
	logic [7:0]  got[$];
	int          tt[$];
	int          cyc, blk, idx, num_errors, n_checks;
	logic [7:0]  e_ok[$] = {8'h05, 8'h01, 8'h41, 8'h42, 8'h03, 8'h00, 8'h02, 8'h30, 8'h30,
		8'h30, 8'h30, 8'h31, 8'h41, 8'h42, 8'h03, 8'h31, 8'h04};
	anl_link #(.P_CYC_PER_SEC(TPS)) i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_tx_data(o_tx_data),
		.o_tx_valid(o_tx_valid), .i_tx_ready(tx_ready), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
		.o_blk_rd(o_blk_rd), .i_blk_data(i_blk_data), .i_blk_last(i_blk_last), .i_blk_final(i_blk_final),
		.o_blk_next(o_blk_next), .o_blk_rewind(o_blk_rewind), .o_busy(o_busy), .o_done(o_done),
		.o_abnormal(o_abnormal));
	anl_peer i_peer (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
		.o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_r_enq(r_enq), .i_r_blk(r_blk),
		.i_r_eot(r_eot), .i_term(term), .i_bcc_en(bcc_en));
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	// ==========================================================
	// byte log and two-byte block source, final when blk is 1
	// byte stands before the read pulse: the engine takes it while o_blk_rd is high
	assign i_blk_data  = (idx == 0) ? 8'h41 : 8'h42;
	assign i_blk_last  = (idx == 1);
	assign i_blk_final = (blk == 1);
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (o_tx_valid && tx_ready) begin
			got.push_back(o_tx_data);
			tt.push_back(cyc);
		end
		if (o_blk_rd) begin
			idx <= idx + 1;
		end
		if (o_blk_next || o_blk_rewind) begin
			idx <= 0;
		end
		if (o_blk_next) begin
			blk <= blk + 1;
		end
	end
	// ==========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_addr    <= a;
		i_wr_data <= v;
		i_wr      <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rd_data;
		@(posedge i_ref_clk);
	endtask : rd
	task automatic run(input logic [31:0] c, input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
		r_enq <= a;
		r_blk <= b;
		r_eot <= e;
		blk   <= 0;
		idx   <= 0;
		got.delete();
		tt.delete();
		wr(anl_pkg::A_CTRL, c | 32'h1);
		#1 check(32'(o_busy), 32'h1);
		for (int i = 0; i < 4000 && !o_done; i++) begin
			@(posedge i_ref_clk);
			#1;
		end
		if (!o_done) begin
			num_errors++;
			wrap_up();
		end
	endtask : run
	// ==========================================================
	// main sequence
	initial begin
		{i_rstn, i_wr, i_rd, bcc_en, cyc, blk, idx, num_errors, n_checks} = '0;
		{i_addr, i_wr_data, r_enq, r_blk, r_eot} = '0;
		term = 8'h03;
		repeat (20) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		@(posedge i_ref_clk);
		rd(anl_pkg::A_CFG);
		check(d, 32'h1e0a);
		rd(anl_pkg::A_CHAR);
		check(d, 32'h030201);
		rd(anl_pkg::A_TICK);
		check(d, TPS);
		rd(8'h3c);
		check(d, 32'h0);
		$display("test registers ended");
		bcc_en <= 1'b1;
		run(32'hc, 8'h06, 8'h06, 8'h06);
		check(32'(got.size()), 32'd17);
		foreach (e_ok[i]) check(32'(got[i]), 32'(e_ok[i]));
		rd(anl_pkg::A_STAT);
		check(32'({d[2:0], o_abnormal}), 32'h4);
		$display("test clean transfer ended");
		bcc_en <= 1'b0;
		term   <= 8'h13;
		wr(anl_pkg::A_CHAR, 32'h131211);
		run(32'h0, 8'h06, 8'h15, 8'h06);
		check(32'(got.size()), 32'd42);
		check({got[5], got[4], got[41], 7'h0, o_abnormal}, 32'h11130401);
		term <= 8'h03;
		wr(anl_pkg::A_CHAR, 32'h030201);
		$display("test nak limit ended");
		run(32'h0, 8'h06, 8'h04, 8'h06);
		check(32'(got.size()), 32'd6);
		check({got[0], got[4], got[5], 7'h0, o_abnormal}, 32'h05030401);
		$display("test abort by peer ended");
		run(32'h0, 8'h06, 8'h06, 8'h00);
		check(32'(got.size()), 32'd19);
		check({got[5], got[8], got[18], 7'h0, o_abnormal}, 32'h02030401);
		$display("test silent release ended");
		wr(anl_pkg::A_CFG, 32'h1e02);
		run(32'h0, 8'h00, 8'h06, 8'h06);
		check(32'(got.size()), 32'd3);
		check({got[1], got[2], 15'h0, o_abnormal}, 32'h05040001);
		check(32'(tt[1] - tt[0] >= 3 * TPS && tt[1] - tt[0] <= 3 * TPS + 7), 32'h1);
		check(32'(tt[2] - tt[1] >= 3 * TPS && tt[2] - tt[1] <= 3 * TPS + 7), 32'h1);
		$display("test silent setup ended");
		r_enq <= 8'h00;
		r_eot <= 8'h00;
		got.delete();
		repeat (10) @(posedge i_ref_clk);
		wr(anl_pkg::A_CTRL, 32'h1);
		repeat (8) @(posedge i_ref_clk);
		wr(anl_pkg::A_CTRL, 32'h2);
		repeat (20) @(posedge i_ref_clk);
		check({got[0], got[1], 6'h0, o_done, o_abnormal, 8'(got.size())}, 32'h05040302);
		$display("test abort by host ended");
		wrap_up();
	end
endmodule : testbench
